//--- design/dac_load_pkg.sv
// Purpose: shared constants and types of the serial load path of a 16-bit converter
// Assumes: one system clock plus the serial clock of the link
// Notes:   widths, counts and the mid-scale code of the control module live here; word_fifo uses none of them
package dac_load_pkg;

  // word layout of the data registers
  localparam int WORD_W         = 16;
  localparam int SEG_BITS       = 4;
  localparam int LADDER_BITS    = 12;
  localparam int SEG_SWITCHES   = 15;
  localparam int SEG_LSB        = 12;
  localparam int FULL_SCALE     = 65536;   // output = reference * code / this

  // power-on code of input register and converter latch
  localparam logic [15:0] MIDSCALE_CODE = 16'h8000;

  // serial bit counting
  localparam int          CNT_W         = 5;
  localparam logic [4:0]  BITS_PER_WORD = 5'h10;
  localparam logic [4:0]  CNT_SATURATE  = 5'h1F;
  localparam logic [4:0]  CNT_ONE       = 5'h01;
  localparam logic [4:0]  CNT_ZERO      = 5'h00;

  // buffer between frame capture and input register
  localparam int FIFO_DEPTH  = 8;
  localparam int FIFO_W      = WORD_W + 2;   // word, short flag, long flag
  localparam int FLAG_SHORT  = 16;
  localparam int FLAG_LONG   = 17;

  // frame capture sequencer, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FRAME = 3'b010,
    ST_PUSH  = 3'b100
  } cap_state_t;

endpackage : dac_load_pkg

//--- design/word_fifo.sv
// Purpose: synchronous FIFO with valid and ready on both sides
// Assumes: single clock, asynchronous active-high reset
// Notes:   one spare pointer bit separates full from empty
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } fifo_state_t;

  fifo_state_t            s_reg;
  fifo_state_t            s_next;
  logic [WIDTH-1:0]       mem [DEPTH];
  logic                   full;
  logic                   empty;
  logic                   do_push;
  logic                   do_pop;

  // honest flags from pointer compare
  assign empty     = (s_reg.wr_ptr == s_reg.rd_ptr);
  assign full      = (s_reg.wr_ptr[AW-1:0] == s_reg.rd_ptr[AW-1:0]) &&
                     (s_reg.wr_ptr[AW] != s_reg.rd_ptr[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[s_reg.rd_ptr[AW-1:0]];
  assign do_push   = in_valid && !full;
  assign do_pop    = out_ready && !empty;

  // pointer advance
  always_comb begin
    s_next = s_reg;
    if (do_push) begin
      s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
    end
    if (do_pop) begin
      s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // storage needs no reset; empty masks stale words
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[s_reg.wr_ptr[AW-1:0]] <= in_data;
    end
  end

endmodule : word_fifo

//--- design/dac_serial_load_control.sv
// Purpose: serial load path of a 16-bit converter: shift, input register, latch
// Assumes: link logic on the serial clock, core logic on clk at 40 MHz
// Notes:   the word crosses when chip select has been high for two core cycles
`timescale 1ns/1ps

// Behaviour
// RQ1: chip select high: serial clock, data ignored
// RQ2: chip select low: shift data in, MSB first
// RQ3: master drives select, clock, data on falls
// RQ4: select rising copies shift register to input
// RQ5: registers 16 bits; word is 16 clocks
// RQ6: master raises select after sixteenth clock
// RQ7: extra clocks: last 16 bits are kept
// RQ8: short word keeps previous bits in shifter
// RQ9: master keeps select low, resends bad words
// RQ10: low strobe after select updates latch
// RQ11: master holds strobe high during frames
// RQ12: strobe tied low: latch follows input register
// RQ13: reset presets input register, latch mid-scale
// RQ14: shift register is never cleared by reset
// RQ15: master sends full words, zero-pads LSBs
// RQ16: top four bits thermometer, twelve drive ladder
// RQ17: latch code is plain unsigned binary
// RQ18: strobe active low, latch follows while low
module dac_serial_load_control
  import dac_load_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic                    sdi,
  input  wire logic                    latch_load_strobe_n,
  input  wire logic                    update_hold,
  output logic [WORD_W-1:0]            input_word,
  output logic [WORD_W-1:0]            latch_code,
  output logic [SEG_SWITCHES-1:0]      segment_switches,
  output logic [LADDER_BITS-1:0]       ladder_switches,
  output logic                         short_frame,
  output logic                         long_frame,
  output logic                         overrun
);

  // ------------------------------------------------------------------
  // link domain, clocked by the serial clock of the master
  // ------------------------------------------------------------------

  typedef struct packed {
    logic             tag;
    logic [CNT_W-1:0] count;
  } link_ctl_t;

  logic [WORD_W-1:0]  shift_reg;
  logic [WORD_W-1:0]  shift_next;
  link_ctl_t          lctl_reg;
  link_ctl_t          lctl_next;
  logic               armed_reg;

  // shift one bit per rising serial edge while selected
  always_comb begin
    shift_next = shift_reg;
    if (!cs_n) begin                                  // RQ1
      shift_next = {shift_reg[WORD_W-2:0], sdi};      // RQ2
    end
  end

  // shifter has no reset at all, so it powers up undefined
  always_ff @(posedge sclk) begin
    shift_reg <= shift_next;                          // RQ14
  end

  // bit counter restarts on the first edge of each frame
  always_comb begin
    lctl_next = lctl_reg;
    if (!cs_n) begin                                  // RQ1
      if (armed_reg) begin
        lctl_next.count = CNT_ONE;
        lctl_next.tag   = !lctl_reg.tag;              // marks a frame with edges
      end else if (lctl_reg.count != CNT_SATURATE) begin
        lctl_next.count = lctl_reg.count + CNT_ONE;
      end
    end
  end

  // select high re-arms the counter without needing a serial edge,
  // since the serial clock may stand still between frames
  always_ff @(posedge sclk or posedge rst or posedge cs_n) begin
    if (rst) begin
      armed_reg <= 1'b1;
    end else if (cs_n) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= 1'b0;
    end
  end

  // count and tag hold across select high, so the core can still
  // read the length of the frame after it has seen the rise
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      lctl_reg <= '{tag: 1'b0, count: CNT_ZERO};
    end else begin
      lctl_reg <= lctl_next;
    end
  end

  // ------------------------------------------------------------------
  // core domain, clocked by clk
  // ------------------------------------------------------------------

  typedef struct packed {
    logic                    cs_meta;
    logic                    cs_sync;
    logic                    cs_prev;
    logic                    ld_meta;
    logic                    ld_sync;
    cap_state_t              state;
    logic                    tag_seen;
    logic [FIFO_W-1:0]       cap_data;
    logic                    cap_valid;
    logic [WORD_W-1:0]       input_reg;
    logic [WORD_W-1:0]       latch_reg;
    logic [SEG_SWITCHES-1:0] seg_reg;
    logic [LADDER_BITS-1:0]  ladder_reg;
    logic                    short_reg;
    logic                    long_reg;
    logic                    overrun_reg;
  } core_state_t;

  core_state_t        c_reg;
  core_state_t        c_next;
  logic [FIFO_W-1:0]  fifo_out_data;
  logic               fifo_out_valid;
  logic               fifo_in_ready;
  logic               fifo_pop;
  logic               cs_rise;
  logic               cs_fall;
  logic [CNT_W-1:0]   frame_bits;

  // edges seen only on the second synchroniser stage
  assign cs_rise  = c_reg.cs_sync && !c_reg.cs_prev;
  assign cs_fall  = !c_reg.cs_sync && c_reg.cs_prev;

  // a frame with no serial edge leaves the tag unchanged: zero bits
  assign frame_bits = (lctl_reg.tag != c_reg.tag_seen) ? lctl_reg.count : CNT_ZERO;

  // the drain stalls while the user holds updates off
  assign fifo_pop = fifo_out_valid && !update_hold;

  always_comb begin
    c_next = c_reg;

    // two-stage synchronisers for both pins
    c_next.cs_meta = cs_n;
    c_next.cs_sync = c_reg.cs_meta;
    c_next.cs_prev = c_reg.cs_sync;
    c_next.ld_meta = latch_load_strobe_n;
    c_next.ld_sync = c_reg.ld_meta;

    // one-cycle event flags
    c_next.short_reg = 1'b0;
    c_next.long_reg  = 1'b0;

    // capture sequencer: wait for select low, then for its rise
    case (c_reg.state)
      ST_IDLE: begin
        if (cs_fall) begin
          c_next.state = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (cs_rise) begin
          // shifter is quiet now: select high freezes it
          c_next.cap_data[WORD_W-1:0] = shift_reg;                    // RQ4
          c_next.cap_data[FLAG_SHORT] = (frame_bits < BITS_PER_WORD);  // RQ5 RQ8
          c_next.cap_data[FLAG_LONG]  = (frame_bits > BITS_PER_WORD);  // RQ5 RQ7
          c_next.tag_seen  = lctl_reg.tag;
          c_next.cap_valid = 1'b1;
          c_next.state     = ST_PUSH;
        end
      end
      ST_PUSH: begin
        // one try only; a full buffer drops the word and flags it
        if (!fifo_in_ready) begin
          c_next.overrun_reg = 1'b1;
        end
        c_next.cap_valid = 1'b0;
        c_next.state     = cs_fall ? ST_FRAME : ST_IDLE;
      end
      default: begin
        c_next.state     = ST_IDLE;
        c_next.cap_valid = 1'b0;
      end
    endcase

    // overrun is sticky until the next accepted word
    if (c_reg.state == ST_PUSH && fifo_in_ready) begin
      c_next.overrun_reg = 1'b0;
    end

    // buffered word lands in the input register
    if (fifo_pop) begin
      c_next.input_reg = fifo_out_data[WORD_W-1:0];                   // RQ4
      c_next.short_reg = fifo_out_data[FLAG_SHORT];                   // RQ8
      c_next.long_reg  = fifo_out_data[FLAG_LONG];                    // RQ7
    end

    // latch is transparent to the input register while strobe is low;
    // a tied-low strobe so follows each load one cycle later
    if (!c_reg.ld_sync) begin                                          // RQ18
      c_next.latch_reg = c_reg.input_reg;                              // RQ10 RQ12
    end

    // segmented decode, computed from the next latch value so the
    // switch outputs change in the same cycle as the latch
    for (int i = 0; i < SEG_SWITCHES; i++) begin
      c_next.seg_reg[i] = (c_next.latch_reg[WORD_W-1:SEG_LSB] > SEG_BITS'(i)); // RQ16
    end
    c_next.ladder_reg = c_next.latch_reg[LADDER_BITS-1:0];             // RQ16
  end

  // reset values: mid-scale in input register and latch,
  // with the decode of that code on the switch outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_reg             <= '0;
      c_reg.cs_meta     <= 1'b1;
      c_reg.cs_sync     <= 1'b1;
      c_reg.cs_prev     <= 1'b1;
      c_reg.ld_meta     <= 1'b1;
      c_reg.ld_sync     <= 1'b1;
      c_reg.state       <= ST_IDLE;
      c_reg.input_reg   <= MIDSCALE_CODE;                              // RQ13
      c_reg.latch_reg   <= MIDSCALE_CODE;                              // RQ13
      c_reg.seg_reg     <= 15'h00FF;
      c_reg.ladder_reg  <= 12'h000;
    end else begin
      c_reg <= c_next;
    end
  end

  // buffer between capture and input register
  word_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (c_reg.cap_data),
    .in_valid  (c_reg.cap_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (!update_hold)
  );

  // all outputs straight from core flip-flops
  assign input_word       = c_reg.input_reg;
  assign latch_code       = c_reg.latch_reg;                           // RQ17
  assign segment_switches = c_reg.seg_reg;
  assign ladder_switches  = c_reg.ladder_reg;
  assign short_frame      = c_reg.short_reg;
  assign long_frame       = c_reg.long_reg;
  assign overrun          = c_reg.overrun_reg;

endmodule : dac_serial_load_control

//--- tb/dac_load_monitor.sv
// Purpose: port checks of the serial load path
// Assumes: the master may clock sclk while cs_n is high; the shadow shifter ignores those edges
// Notes:   a shadow shifter on sclk gives the expected word
`timescale 1ns/1ps
module dac_load_monitor
  import dac_load_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic                    sclk,
  input wire logic                    cs_n,
  input wire logic                    sdi,
  input wire logic                    latch_load_strobe_n,
  input wire logic                    update_hold,
  input wire logic [WORD_W-1:0]       input_word,
  input wire logic [WORD_W-1:0]       latch_code,
  input wire logic [SEG_SWITCHES-1:0] segment_switches,
  input wire logic [LADDER_BITS-1:0]  ladder_switches,
  input wire logic                    short_frame,
  input wire logic                    long_frame,
  input wire logic                    overrun
);
  logic [15:0] shadow_reg;  // not reset, like the real shifter
  logic [4:0]  quiet_reg;   // cycles since update_hold was high
  // shadow shifter, only while selected
  always_ff @(posedge sclk) begin
    if (!cs_n) begin
      shadow_reg <= {shadow_reg[14:0], sdi};
    end
  end
  // a held buffer may still hold old words, so wait for it to drain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_reg <= 5'h00;
    end else if (update_hold) begin
      quiet_reg <= 5'h00;
    end else if (quiet_reg != 5'h1F) begin
      quiet_reg <= quiet_reg + 5'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_midscale:
    assert property ($fell(rst) |-> input_word == 16'h8000 && latch_code == 16'h8000)
    else $error("reset code wrong");
  a_reset_flags:
    assert property ($fell(rst) |-> !short_frame && !long_frame && !overrun)
    else $error("flags set at reset");
  a_segment_decode:
    assert property (segment_switches == 15'((16'h0001 << latch_code[15:12]) - 16'h0001))
    else $error("segment decode wrong");
  a_ladder_direct:
    assert property (ladder_switches == latch_code[11:0])
    else $error("ladder field wrong");
  a_latch_holds:
    assert property (latch_load_strobe_n [*4] |=> $stable(latch_code))
    else $error("latch moved with strobe high");
  a_latch_follows:
    assert property (!latch_load_strobe_n [*4] |=> latch_code == $past(input_word))
    else $error("latch not following");
  a_word_load:
    assert property ($rose(cs_n) && quiet_reg == 5'h1F |-> ##[5:6] input_word == shadow_reg)
    else $error("loaded word wrong");
  a_flags_one:
    assert property (!(short_frame && long_frame))
    else $error("short and long together");
  c_short: cover property (short_frame);
  c_long: cover property (long_frame);
  c_overrun: cover property (overrun);
endmodule : dac_load_monitor
bind dac_serial_load_control dac_load_monitor #(.DEPTH(DEPTH)) mon (
  .clk                 (clk),
  .rst                 (rst),
  .sclk                (sclk),
  .cs_n                (cs_n),
  .sdi                 (sdi),
  .latch_load_strobe_n (latch_load_strobe_n),
  .update_hold         (update_hold),
  .input_word          (input_word),
  .latch_code          (latch_code),
  .segment_switches    (segment_switches),
  .ladder_switches     (ladder_switches),
  .short_frame         (short_frame),
  .long_frame          (long_frame),
  .overrun             (overrun)
);

//--- tb/spi_master_model.sv
// Purpose: bus master that drives the three-wire link
// Assumes: link clock of 6 ns, still between frames except while noise clocks it
// Notes:   idle data shows the inverse of its last bit
`timescale 1ns/1ps
module spi_master_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // one frame, n bits msb first; data moves on falls
  task automatic send(input logic [31:0] w, input int n);
    #1.3 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    #(n < 14 ? 90 - 6 * n : 2) cs_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask : send
  // clocks and data with select high
  task automatic noise();
    for (int i = 0; i < 8; i++) begin
      sdi = ~sdi;
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    #200;
  endtask : noise
endmodule : spi_master_model

//--- tb/dac_serial_load_control_tb_top.sv
// Purpose: self-checking bench of the serial load path
// Assumes: master model drives the link, bench drives strobe and hold
// Notes:   drivers queue expected words, a watcher checks each load
`timescale 1ns/1ps
module dac_serial_load_control_tb_top
  import dac_load_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        latch_load_strobe_n;
  logic        update_hold;
  logic [15:0] input_word;
  logic [15:0] latch_code;
  logic [14:0] segment_switches;
  logic [11:0] ladder_switches;
  logic        short_frame;
  logic        long_frame;
  logic        overrun;
  int          mismatches;
  int          compares;
  logic [31:0] seed;
  logic [15:0] sh;            // expected shifter content
  logic [15:0] prev;
  logic [15:0] seen;
  logic [17:0] expq[$];       // long, short, word
  logic [17:0] e;
  dac_serial_load_control uut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .latch_load_strobe_n(latch_load_strobe_n), .update_hold(update_hold),
    .input_word(input_word), .latch_code(latch_code), .segment_switches(segment_switches),
    .ladder_switches(ladder_switches), .short_frame(short_frame), .long_frame(long_frame),
    .overrun(overrun));
  spi_master_model m (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));
  always #12.5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // random frame of n bits; the shifter model keeps the last 16
  task automatic frame(input int n, input bit keep);
    logic [31:0] w;
    seed = lfsr(seed);
    w = seed;
    for (int i = n - 1; i >= 0; i--) begin
      sh = {sh[14:0], w[i]};
    end
    if (keep) begin
      expq.push_back({1'(n > 16), 1'(n < 16), sh});
    end
    m.send(w, n);
  endtask : frame
  task automatic stop_test();
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // watcher: every move of the input register takes one note
  always @(negedge clk) begin
    if (!rst && input_word !== seen) begin
      seen = input_word;
      chk(32'(expq.size() > 0), 1, "unexpected load");
      if (expq.size() > 0) begin
        e = expq.pop_front();
        chk(input_word, e[15:0], "word");
        chk({long_frame, short_frame}, e[17:16], "flags");
      end
    end
  end
  initial begin
    #50000;
    mismatches++;
    stop_test();
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    latch_load_strobe_n = 1'b0;
    update_hold = 1'b0;
    mismatches = 0;
    compares = 0;
    seed = 32'h4C270BD3;
    seen = 16'h8000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(latch_code, 16'h8000, "reset latch");
    chk(segment_switches, 15'h00FF, "reset segments");
    // strobe tied low: latch follows each load
    for (int k = 0; k < 4; k++) begin
      frame(16, 1'b1);
      chk(latch_code, sh, "latch");
      chk(segment_switches, 15'((16'h0001 << sh[15:12]) - 16'h0001), "segments");
      chk(ladder_switches, sh[11:0], "ladder");
    end
    frame(20, 1'b1);
    m.noise();
    frame(8, 1'b1);
    // separate update through the strobe
    @(posedge clk);
    latch_load_strobe_n <= 1'b1;
    repeat (4) @(posedge clk);
    prev = sh;
    frame(16, 1'b1);
    chk(latch_code, prev, "latch held");
    @(posedge clk);
    latch_load_strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(latch_code, sh, "latch update");
    // hold the buffer: eight kept, the ninth dropped
    @(posedge clk);
    update_hold <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      frame(16, k < 8);
    end
    chk(overrun, 1, "overrun set");
    @(posedge clk);
    update_hold <= 1'b0;
    repeat (40) @(posedge clk);
    frame(16, 1'b1);
    chk(overrun, 0, "overrun clear");
    for (int k = 0; k < 50 && expq.size() > 0; k++) begin
      @(posedge clk);
    end
    chk(32'(expq.size()), 0, "missing loads");
    stop_test();
  end
endmodule : dac_serial_load_control_tb_top
